/* File: phs_pkg.sv */
package phs_pkg;
  // command codes of the registers on the management port
  localparam logic [7:0] ADDR_EVENT_CAPTURE = 8'h3a;
  localparam logic [7:0] ADDR_PULSE_CONTROL = 8'h3c;
  localparam logic [7:0] ADDR_PROFILE_LIMIT = 8'h3d;

  // profile / status bit positions
  localparam int SRC_CMP = 6;
  localparam int SRC_CRIT = 5;
  localparam int SRC_NOM = 4;
  localparam int SRC_DCHG = 3;
  localparam int SRC_SYSV = 2;
  localparam int SRC_BAT = 1;
  localparam int SRC_ADP = 0;
  localparam int NUM_SRC = 7;

  // sources that survive adapter removal
  localparam logic [6:0] KEEP_NO_ADAPTER = 7'h4c;
  localparam logic [6:0] ALL_SOURCES = 7'h7f;

  // profile register fields
  localparam int VTH_LSB = 10;
  localparam int VTH_MSB = 15;
  localparam int DEG_LSB = 8;
  localparam int DEG_MSB = 9;
  localparam logic [5:0] VTH_RESET = 6'h20;
  localparam logic [1:0] DEG_RESET = 2'h0;
  localparam logic [6:0] PROFILE_RESET = 7'h20;
  localparam int VTH_STEP_SHIFT = 9; // 512 mA per code

  // pulse control register fields
  localparam int EXT_BIT = 5;
  localparam int WIDTH_LSB = 3;
  localparam int WIDTH_MSB = 4;
  localparam int CLEAR_BIT = 2;
  localparam logic [1:0] WIDTH_RESET = 2'h2;

  typedef enum logic [1:0] {
    PHS_W_100US = 2'b00,
    PHS_W_1MS = 2'b01,
    PHS_W_10MS = 2'b10,
    PHS_W_5MS = 2'b11
  } phs_width_e;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_100US_NS = 100000;
  localparam int T_1MS_NS = 1000000;
  localparam int T_5MS_NS = 5000000;
  localparam int T_10MS_NS = 10000000;
  // least times round up; worked in ns so the 10 ms figure stays inside a 32-bit int
  localparam int CYC_100US = (T_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_1MS = (T_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_5MS = (T_5MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_10MS = (T_10MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 22;
endpackage

/* File: phs_alert.sv */
`timescale 1ns/1ps
module phs_alert
  import phs_pkg::*;
#(
  parameter int P_CYC_100US = CYC_100US,
  parameter int P_CYC_1MS = CYC_1MS,
  parameter int P_CYC_5MS = CYC_5MS,
  parameter int P_CYC_10MS = CYC_10MS
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_comparator_trip,
  input wire logic i_critical_current_trip,
  input wire logic i_nominal_current_trip,
  input wire logic i_system_voltage_low,
  input wire logic i_battery_present,
  input wire logic i_adapter_ok,
  input wire logic [15:0] i_discharge_current_ma,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_proc_hot_alert_n
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // the analog side runs unclocked, so every level and the current word pass two flops
  logic [5:0] pin_s1_q, pin_s2_q;
  logic [15:0] dchg_s1_q, dchg_s2_q;
  logic bat_prev_q, adp_prev_q;
  logic [15:0] dchg_q;

  always_ff @(posedge i_sys_clk) begin
    // no reset: the chain tracks the pins through reset, so a level already high is no edge
    pin_s1_q <= {i_comparator_trip, i_critical_current_trip, i_nominal_current_trip,
                 i_system_voltage_low, i_battery_present, i_adapter_ok};
    pin_s2_q <= pin_s1_q;
    dchg_s1_q <= i_discharge_current_ma;
    dchg_s2_q <= dchg_s1_q;
    // the word is taken only once two samples agree, so a half-settled value never compares
    if (dchg_s1_q == dchg_s2_q) begin
      dchg_q <= dchg_s2_q;
    end
    bat_prev_q <= pin_s2_q[1];
    adp_prev_q <= pin_s2_q[0];
  end

  // mask follows the adapter one cycle late, so the adapter-ok fall itself can still alert
  wire logic adapter_present = adp_prev_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [5:0] vth_q;
  logic [1:0] deg_q;
  logic [6:0] profile_q;
  logic ext_q;
  logic [1:0] width_q;
  logic clear_q;
  logic active_q;

  wire logic wr_prof = i_reg_wr && (i_reg_addr == ADDR_PROFILE_LIMIT);
  wire logic wr_ctrl = i_reg_wr && (i_reg_addr == ADDR_PULSE_CONTROL);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      vth_q <= VTH_RESET;
      deg_q <= DEG_RESET;
      profile_q <= PROFILE_RESET;
    end else if (wr_prof) begin
      vth_q <= i_reg_wdata[VTH_MSB:VTH_LSB];
      deg_q <= i_reg_wdata[DEG_MSB:DEG_LSB];
      profile_q <= i_reg_wdata[NUM_SRC-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ext_q <= 1'b0;
      width_q <= WIDTH_RESET;
      clear_q <= 1'b1;
    end else begin
      if (wr_ctrl) begin
        ext_q <= i_reg_wdata[EXT_BIT];
        width_q <= i_reg_wdata[WIDTH_MSB:WIDTH_LSB];
      end
      // clear bit returns to idle once the pulse is over
      if (wr_ctrl)
        clear_q <= i_reg_wdata[CLEAR_BIT];
      else if (!active_q)
        clear_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  logic [6:0] trig_w, mask_w, hit_w;
  logic [15:0] dchg_limit_w;
  always_comb begin
    dchg_limit_w = {vth_q, 10'h000} >> (VTH_LSB - VTH_STEP_SHIFT);
    trig_w = '0;
    trig_w[SRC_CMP] = pin_s2_q[5];
    trig_w[SRC_CRIT] = pin_s2_q[4];
    trig_w[SRC_NOM] = pin_s2_q[3];
    trig_w[SRC_DCHG] = dchg_q > dchg_limit_w;
    trig_w[SRC_SYSV] = pin_s2_q[2];
    trig_w[SRC_BAT] = pin_s2_q[1] && !bat_prev_q;
    trig_w[SRC_ADP] = !pin_s2_q[0] && adp_prev_q;
    mask_w = profile_q & (adapter_present ? ALL_SOURCES : KEEP_NO_ADAPTER);
    hit_w = trig_w & mask_w;
  end

  wire logic fire_w = |hit_w;

  // ----------------------------------------------------------------
  // alert pulse
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] width_cyc_w;
  always_comb begin
    unique case (phs_width_e'(width_q))
      PHS_W_100US: width_cyc_w = CNT_W'(P_CYC_100US - 1);
      PHS_W_1MS: width_cyc_w = CNT_W'(P_CYC_1MS - 1);
      PHS_W_10MS: width_cyc_w = CNT_W'(P_CYC_10MS - 1);
      PHS_W_5MS: width_cyc_w = CNT_W'(P_CYC_5MS - 1);
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      active_q <= 1'b0;
      cnt_q <= '0;
      o_proc_hot_alert_n <= 1'b1;
    end else begin
      if (fire_w) begin
        // enabled trigger starts or stretches a pulse
        active_q <= 1'b1;
        cnt_q <= width_cyc_w;
        o_proc_hot_alert_n <= 1'b0;
      end else if (active_q && ext_q) begin
        if (!clear_q) begin
          active_q <= 1'b0;
          o_proc_hot_alert_n <= 1'b1;
        end
      end else if (active_q) begin
        if (cnt_q == '0) begin
          active_q <= 1'b0;
          o_proc_hot_alert_n <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status capture and readback
  // ----------------------------------------------------------------
  logic [6:0] status_q;
  logic armed_q;
  wire logic rd_stat = i_reg_rd && (i_reg_addr == ADDR_EVENT_CAPTURE);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      status_q <= '0;
      armed_q <= 1'b0;
    end else if (fire_w && !active_q) begin
      status_q <= hit_w;
      armed_q <= 1'b0;
    end else if (active_q) begin
      status_q <= status_q | hit_w;
      armed_q <= 1'b1;
    end else if (rd_stat && armed_q) begin
      status_q <= '0;
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_EVENT_CAPTURE: o_reg_rdata <= {9'h000, status_q};
        ADDR_PULSE_CONTROL: o_reg_rdata <= {10'h000, ext_q, width_q, clear_q, 2'h0};
        ADDR_PROFILE_LIMIT: o_reg_rdata <= {vth_q, deg_q, 1'b0, profile_q};
        default: o_reg_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_pulse_start;
    !active_q ##1 active_q;
  endsequence

  AST_VTH_RESET: assert property (@(posedge i_sys_clk) !i_rstn |=> vth_q == VTH_RESET)
    else $error("threshold reset wrong");
  AST_DCHG_COMPARE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    trig_w[SRC_DCHG] == (dchg_q > {1'b0, vth_q, 9'h000}))
    else $error("discharge event missed");
  AST_FIRE_DROPS_ALERT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (trig_w & profile_q & KEEP_NO_ADAPTER) != '0 |=> !o_proc_hot_alert_n)
    else $error("enabled trigger did not drop alert");
  AST_NO_ADAPTER_MASK: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !adapter_present && !active_q && (profile_q & KEEP_NO_ADAPTER) == '0 |=> !active_q)
    else $error("masked source raised alert");
  AST_ZERO_PROFILE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    profile_q == '0 && !active_q |=> o_proc_hot_alert_n)
    else $error("alert with empty profile");
  AST_BAT_ONESHOT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    pin_s2_q[1] && $past(pin_s2_q[1]) |-> !trig_w[SRC_BAT])
    else $error("battery event fired on a steady level");
  AST_ADP_ONESHOT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !pin_s2_q[0] && !$past(pin_s2_q[0]) |-> !trig_w[SRC_ADP])
    else $error("adapter event fired on a steady level");
  AST_STATUS_START: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    s_pulse_start |-> status_q == $past(hit_w))
    else $error("status not restarted on new pulse");
  AST_STATUS_ACCUM: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    active_q ##1 active_q |-> (status_q & $past(status_q)) == $past(status_q))
    else $error("status lost a bit during pulse");
  AST_READ_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    rd_stat && armed_q && !active_q && !fire_w |=> status_q == '0)
    else $error("status not cleared by read");
  AST_MIN_WIDTH: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    active_q && !ext_q && cnt_q != '0 |=> active_q)
    else $error("pulse ended early");
  AST_EXT_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    active_q && ext_q && clear_q |=> active_q)
    else $error("extended pulse ended without clear");
  AST_CLEAR_ENDS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    active_q && ext_q && !clear_q && !fire_w |=> o_proc_hot_alert_n ##1 clear_q)
    else $error("clear did not end pulse");

endmodule

/* File: phs_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// host side: times each alert pulse
// ----------------------------------------
module phs_host_model (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_alert_n,
  output logic [15:0] o_low_cycles,
  output logic [15:0] o_pulses
);
  logic [15:0] run_q;
  logic prev_q;

  // the host only sees the pin, so width is counted in whole clock cycles
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      run_q <= 16'h0;
      prev_q <= 1'b1;
      o_pulses <= 16'h0;
      o_low_cycles <= 16'h0;
    end else begin
      prev_q <= i_alert_n;
      if (!i_alert_n) begin
        run_q <= run_q + 16'h1;
      end
      if (prev_q && !i_alert_n) begin
        o_pulses <= o_pulses + 16'h1;
      end
      if (!prev_q && i_alert_n) begin
        o_low_cycles <= run_q;
        run_q <= 16'h0;
      end
    end
  end
endmodule

/* File: processor_hot_alert_profile_status_bench.sv */
`timescale 1ns/1ps
module processor_hot_alert_profile_status_bench;
  import phs_pkg::*;
  localparam int PW [4] = '{20, 40, 60, 80};
  logic clk, rst_n, wr, rd, rd_tk, alert_n;
  logic [6:0] src;
  logic [7:0] addr;
  logic [15:0] cur, wd, rdata, low_cyc, pulses, np;
  logic [15:0] exp_q [$];
  int mismatches = 0;
  int check_count = 0;
  int code;

  phs_alert #(.P_CYC_100US(20), .P_CYC_1MS(40), .P_CYC_5MS(80), .P_CYC_10MS(60)) phs_alert_inst (
    .i_sys_clk(clk), .i_rstn(rst_n), .i_comparator_trip(src[6]), .i_critical_current_trip(src[5]),
    .i_nominal_current_trip(src[4]), .i_system_voltage_low(src[2]), .i_battery_present(src[1]),
    .i_adapter_ok(src[0]), .i_discharge_current_ma(cur), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_proc_hot_alert_n(alert_n));
  phs_host_model phs_host_model_inst (.i_sys_clk(clk), .i_rstn(rst_n), .i_alert_n(alert_n),
    .o_low_cycles(low_cyc), .o_pulses(pulses));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // pins pass a two-flop synchroniser, so each trip is held four cycles
  task automatic fire(input int s);
    @(posedge clk);
    if (s == SRC_DCHG) cur <= 16'hffff;
    else src[s] <= ~src[s];
    repeat (4) @(posedge clk);
    if (s == SRC_DCHG) cur <= 16'h0;
    else src[s] <= ~src[s];
  endtask
  task automatic wait_al(input logic lvl, input int bound);
    int n;
    n = 0;
    while (alert_n !== lvl && n < bound) begin
      @(negedge clk);
      n++;
    end
    if (alert_n !== lvl) begin
      mismatches++;
      $display("mismatch alert_wait expected %b seen %b", lvl, alert_n);
      end_sim();
    end
  endtask
  task automatic pulse_read(input logic [15:0] e);
    wait_al(1'b0, 12);
    wait_al(1'b1, 100);
    rd_reg(8'h3a, e);
  endtask

  // read data lands on the same edge that takes the read
  always @(posedge clk) rd_tk <= rd;
  always @(negedge clk) begin
    if (rd_tk && exp_q.size() > 0) begin
      check("rdata", exp_q.pop_front(), rdata);
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    src = 7'h01;
    cur = 16'h0;
    addr = 8'h0;
    wr = 1'b0;
    rd = 1'b0;
    wd = 16'h0;
    void'($urandom(21221));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h3d, 16'h8020);
    rd_reg(8'h3c, 16'h0014);
    rd_reg(8'h10, 16'h0000);
    wr_reg(8'h3d, 16'hffff);
    rd_reg(8'h3d, 16'hff7f);
    wr_reg(8'h3a, 16'h007f);
    rd_reg(8'h3a, 16'h0000);
    $display("test registers done");
    wr_reg(8'h3d, 16'h8000);
    np = pulses;
    for (int s = 6; s > 0; s--) fire(s);
    repeat (8) @(posedge clk);
    check("pulses", np, pulses);
    for (int s = 6; s > 0; s--) begin
      wr_reg(8'h3d, 16'h8000 | (16'h1 << s));
      fire(s);
      pulse_read(16'h1 << s);
      rd_reg(8'h3a, 16'h0);
    end
    wr_reg(8'h3d, 16'h8002);
    @(posedge clk);
    src[1] <= 1'b1;
    pulse_read(16'h0002);
    @(posedge clk);
    src[1] <= 1'b0;
    wr_reg(8'h3d, 16'h8001);
    @(posedge clk);
    src[0] <= 1'b0;
    pulse_read(16'h0001);
    @(posedge clk);
    src[0] <= 1'b1;
    $display("test sources done");
    wr_reg(8'h3d, 16'h8032);
    @(posedge clk);
    src[0] <= 1'b0;
    np = pulses;
    fire(5);
    fire(4);
    fire(1);
    repeat (8) @(posedge clk);
    check("pulses", np, pulses);
    wr_reg(8'h3d, 16'h804c);
    fire(2);
    pulse_read(16'h0004);
    @(posedge clk);
    src[0] <= 1'b1;
    wr_reg(8'h3d, 16'h8044);
    for (int j = 0; j < 3; j++) begin
      fire(6);
      if (j != 1) fire(2);
      wait_al(1'b0, 12);
      wait_al(1'b1, 100);
      if (j > 0) rd_reg(8'h3a, (j == 1) ? 16'h0040 : 16'h0044);
    end
    $display("test adapter and capture done");
    code = 1 + $urandom % 62;
    wr_reg(8'h3d, {code[5:0], 10'h008});
    np = pulses;
    @(posedge clk);
    cur <= 16'(code * 512);
    repeat (8) @(posedge clk);
    check("pulses", np, pulses);
    cur <= 16'(code * 512 + 1);
    wait_al(1'b0, 12);
    @(posedge clk);
    cur <= 16'h0;
    pulse_read(16'h0008);
    wr_reg(8'h3d, 16'h8040);
    for (int w = 0; w < 4; w++) begin
      wr_reg(8'h3c, 16'(w * 8 + 4));
      fire(6);
      pulse_read(16'h0040);
      repeat (2) @(posedge clk);
      check("low_cycles", 16'h1, 16'(low_cyc >= PW[w] && low_cyc <= PW[w] + 8));
    end
    wr_reg(8'h3c, 16'h0024);
    fire(6);
    wait_al(1'b0, 12);
    repeat (120) @(posedge clk);
    check("alert_held", 16'h0, 16'(alert_n));
    wr_reg(8'h3c, 16'h0020);
    wait_al(1'b1, 6);
    repeat (4) @(posedge clk);
    rd_reg(8'h3c, 16'h0024);
    repeat (2) @(negedge clk);
    $display("test pulse timing done");
    end_sim();
  end
endmodule
